// >>> rtl/dmem_pkg.sv
// Purpose: Shared constants and carriers for the data memory addressing block
// Assumes: 8-bit core, 256-byte internal data memory, one system clock
// Notes: Offsets are the special function register direct addresses
package dmem_pkg;
  localparam logic [7:0] STACK_PTR_ADDR = 8'h81;
  localparam logic [7:0] STATUS_WORD_ADDR = 8'hD0;
  localparam logic [7:0] STACK_PTR_RESET = 8'h07;
  localparam logic [7:0] STATUS_WORD_RESET = 8'h00;
  localparam int BANK_LO_POS = 3;
  localparam int BANK_HI_POS = 4;
  localparam logic [7:0] BANK_AREA_END = 8'h1F;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam logic [7:0] UPPER_BASE = 8'h80;
  localparam logic [2:0] SFR_BIT_GROUP = 3'h0;
  localparam int DATA_DEPTH = 256;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_DIRECT = 4'h1,
    OP_INDIRECT = 4'h2,
    OP_REGNAME = 4'h3,
    OP_BIT = 4'h4,
    OP_PUSH = 4'h5,
    OP_POP = 4'h6
  } op_kind_t;

  // One request from the execution unit
  typedef struct packed {
    logic valid;
    op_kind_t kind;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  // One answer to the execution unit
  typedef struct packed {
    logic valid;
    logic to_sfr;
    logic sfr_bit_ok;
    logic [7:0] rdata;
    logic bit_val;
  } mem_rsp_t;
endpackage

// >>> rtl/dmem_ram.sv
// Purpose: Single-port internal data memory with registered read data
// Assumes: One access per cycle, write and read never in the same request
// Notes: Contents are not cleared by reset
`timescale 1ns/1ns
module dmem_ram #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clk_sys,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // dmem_ram

// >>> rtl/data_memory_addressing.sv
// Purpose: Address steering, register banks, bit area and stack for internal data memory
// Assumes: Execution unit issues one request at a time and waits for rsp.valid
// Notes: Answer comes two cycles after the request is taken, three for indirect and for bit writes not to SP or status word
`timescale 1ns/1ns
module data_memory_addressing
  import dmem_pkg::*;
#(
  parameter int DEPTH = DATA_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire mem_req_t req,
  input wire logic [7:0] sfr_rdata,
  output mem_rsp_t rsp,
  output logic sfr_we,
  output logic sfr_re,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  output logic [1:0] active_bank,
  output logic [7:0] stack_ptr
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] bank_addr(input logic [7:0] processor_status_word, input logic [2:0] idx);
    bank_addr = {3'h0, processor_status_word[BANK_HI_POS], processor_status_word[BANK_LO_POS], idx};
  endfunction

  function automatic logic sfr_bit_capable(input logic [7:0] a);
    sfr_bit_capable = (a[2:0] == SFR_BIT_GROUP);
  endfunction

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PTR = 4'b0010,
    ST_ACC = 4'b0100,
    ST_DONE = 4'b1000
  } state_t;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_t state_q, state_d;
  mem_req_t cur_q, cur_d;
  logic [7:0] sp_q, sp_d;
  logic [7:0] psw_q, psw_d;
  logic [2:0] bitpos_q, bitpos_d;
  logic sfr_path_q, sfr_path_d;
  logic local_q, local_d;
  logic [7:0] local_val_q, local_val_d;
  mem_rsp_t rsp_d;
  logic sfr_we_d, sfr_re_d;
  logic [7:0] sfr_addr_d, sfr_wdata_d;
  logic ram_we;
  logic [7:0] ram_addr, ram_wdata, ram_rdata;

  dmem_ram #(.DEPTH(DEPTH), .AW(8)) u_ram (
    .clk_sys(clk_sys),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] rd;
    logic [7:0] merged;
    rd = 8'h00;
    merged = 8'h00;
    state_d = state_q;
    cur_d = cur_q;
    sp_d = sp_q;
    psw_d = psw_q;
    bitpos_d = bitpos_q;
    sfr_path_d = sfr_path_q;
    local_d = local_q;
    local_val_d = local_val_q;
    rsp_d = '0;
    sfr_we_d = 1'b0;
    sfr_re_d = 1'b0;
    sfr_addr_d = sfr_addr;
    sfr_wdata_d = sfr_wdata;
    ram_we = 1'b0;
    ram_addr = 8'h00;
    ram_wdata = 8'h00;
    case (state_q)
      ST_IDLE: begin
        // The caller still holds the request while the answer stands, so skip that cycle
        if (req.valid && !rsp.valid) begin
          cur_d = req;
          sfr_path_d = 1'b0;
          local_d = 1'b0;
          bitpos_d = 3'h0;
          case (req.kind)
            OP_REGNAME: begin
              cur_d.addr = bank_addr(psw_q, req.addr[2:0]);
              state_d = ST_ACC;
            end
            OP_INDIRECT: begin
              ram_addr = bank_addr(psw_q, {2'b00, req.addr[0]});
              state_d = ST_PTR;
            end
            OP_BIT: begin
              // Bit kind alone selects bit access
              if (req.addr < UPPER_BASE) begin
                cur_d.addr = BIT_AREA_BASE + {4'h0, req.addr[6:3]};
              end else begin
                cur_d.addr = {req.addr[7:3], 3'h0};
                sfr_path_d = 1'b1;
              end
              bitpos_d = req.addr[2:0];
              state_d = ST_ACC;
            end
            OP_PUSH: begin
              cur_d.addr = sp_q + 8'h01;
              cur_d.write = 1'b1;
              sp_d = sp_q + 8'h01;
              state_d = ST_ACC;
            end
            OP_POP: begin
              cur_d.addr = sp_q;
              cur_d.write = 1'b0;
              sp_d = sp_q - 8'h01;
              state_d = ST_ACC;
            end
            OP_DIRECT: begin
              sfr_path_d = (req.addr >= UPPER_BASE);
              state_d = ST_ACC;
            end
            default: begin
              state_d = ST_ACC;
              local_d = 1'b1;
            end
          endcase
        end
      end
      ST_PTR: begin
        // Pointer byte arrives; indirect never reaches the special space
        cur_d.addr = ram_rdata;
        state_d = ST_ACC;
      end
      ST_ACC: begin
        state_d = ST_DONE;
        if (sfr_path_q) begin
          if (cur_q.addr == STACK_PTR_ADDR || cur_q.addr == STATUS_WORD_ADDR) begin
            local_d = 1'b1;
            local_val_d = (cur_q.addr == STACK_PTR_ADDR) ? sp_q : psw_q;
            if (cur_q.write && cur_q.kind == OP_BIT) begin
              merged = local_val_d;
              merged[bitpos_q] = cur_q.wdata[0];
            end else begin
              merged = cur_q.wdata;
            end
            if (cur_q.write && cur_q.addr == STACK_PTR_ADDR) sp_d = merged;
            if (cur_q.write && cur_q.addr == STATUS_WORD_ADDR) psw_d = merged;
          end else begin
            sfr_addr_d = cur_q.addr;
            sfr_re_d = 1'b1;
            if (cur_q.write && cur_q.kind == OP_BIT) begin
              // Bit write fetches the whole register first, then writes it back
              cur_d.kind = OP_NONE;
              state_d = ST_ACC;
            end else if (cur_q.write && cur_q.kind == OP_NONE) begin
              merged = sfr_rdata;
              merged[bitpos_q] = cur_q.wdata[0];
              sfr_we_d = 1'b1;
              sfr_wdata_d = merged;
            end else if (cur_q.write) begin
              sfr_we_d = 1'b1;
              sfr_wdata_d = cur_q.wdata;
            end
          end
        end else if (cur_q.kind == OP_BIT && cur_q.write) begin
          // Read-modify-write on the bit area needs the byte first
          ram_addr = cur_q.addr;
          cur_d.kind = OP_NONE;
          state_d = ST_ACC;
          local_d = 1'b1;
        end else if (local_q && cur_q.kind == OP_NONE) begin
          merged = ram_rdata;
          merged[bitpos_q] = cur_q.wdata[0];
          ram_addr = cur_q.addr;
          ram_we = 1'b1;
          ram_wdata = merged;
          local_val_d = merged;
        end else if (!local_q) begin
          ram_addr = cur_q.addr;
          ram_we = cur_q.write;
          ram_wdata = cur_q.wdata;
        end
      end
      ST_DONE: begin
        if (local_q) rd = local_val_q;
        else if (sfr_path_q) rd = sfr_rdata;
        else rd = ram_rdata;
        rsp_d.valid = 1'b1;
        rsp_d.to_sfr = sfr_path_q;
        rsp_d.sfr_bit_ok = sfr_path_q && sfr_bit_capable(cur_q.addr);
        rsp_d.rdata = rd;
        rsp_d.bit_val = rd[bitpos_q];
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      cur_q <= '0;
      sp_q <= STACK_PTR_RESET;
      psw_q <= STATUS_WORD_RESET;
      bitpos_q <= 3'h0;
      sfr_path_q <= 1'b0;
      local_q <= 1'b0;
      local_val_q <= 8'h00;
      rsp <= '0;
      sfr_we <= 1'b0;
      sfr_re <= 1'b0;
      sfr_addr <= 8'h00;
      sfr_wdata <= 8'h00;
      active_bank <= 2'h0;
      stack_ptr <= STACK_PTR_RESET;
    end else begin
      state_q <= state_d;
      cur_q <= cur_d;
      sp_q <= sp_d;
      psw_q <= psw_d;
      bitpos_q <= bitpos_d;
      sfr_path_q <= sfr_path_d;
      local_q <= local_d;
      local_val_q <= local_val_d;
      rsp <= rsp_d;
      sfr_we <= sfr_we_d;
      sfr_re <= sfr_re_d;
      sfr_addr <= sfr_addr_d;
      sfr_wdata <= sfr_wdata_d;
      active_bank <= {psw_d[BANK_HI_POS], psw_d[BANK_LO_POS]};
      stack_ptr <= sp_d;
    end
  end
endmodule // data_memory_addressing

// >>> verif/dmem_asserts.sv
// Purpose: Port-level checks for data_memory_addressing
// Assumes: Requests are held until rsp.valid
// Notes: Bound to the top module after endmodule
`timescale 1ns/1ns
module dmem_asserts
  import dmem_pkg::*;
#(
  parameter int DEPTH = 256
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire mem_req_t req,
  input wire logic [7:0] sfr_rdata,
  input wire mem_rsp_t rsp,
  input wire logic sfr_we,
  input wire logic sfr_re,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [1:0] active_bank,
  input wire logic [7:0] stack_ptr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_sp_reset: assert property ($rose(rstn) |-> stack_ptr == STACK_PTR_RESET)
    else $error("stack pointer not at reset value");
  // Pointer moves only by one step or by a direct write to its own address
  a_sp_moves: assert property ($changed(stack_ptr) |-> $past(req.valid) &&
    ($past(req.kind) == OP_PUSH ? stack_ptr == $past(stack_ptr) + 8'h01 :
    $past(req.kind) == OP_POP ? stack_ptr == $past(stack_ptr) - 8'h01 :
    $past(req.addr) == STACK_PTR_ADDR))
    else $error("stack pointer moved wrongly");
  a_bank_cause: assert property ($changed(active_bank) |->
    $past(req.write) && $past(req.addr[7:3]) == 5'h1A)
    else $error("bank changed without status word write");
  a_sfr_cause: assert property ((sfr_re || sfr_we) |-> sfr_addr[7] &&
    (req.kind == OP_DIRECT || req.kind == OP_BIT))
    else $error("special space strobe from wrong access");
  a_sfr_addr: assert property (sfr_re && req.kind == OP_DIRECT |-> sfr_addr == req.addr)
    else $error("special space address differs");
  a_indirect_ram: assert property (rsp.valid && req.kind == OP_INDIRECT |-> !rsp.to_sfr)
    else $error("indirect access steered to special space");
  a_direct_steer: assert property (rsp.valid && req.kind == OP_DIRECT |->
    rsp.to_sfr == req.addr[7])
    else $error("direct access steered wrongly");
  a_bit_group: assert property (rsp.valid && req.kind == OP_DIRECT && req.addr[7] |->
    rsp.sfr_bit_ok == (req.addr[2:0] == SFR_BIT_GROUP))
    else $error("bit capability flag wrong");
endmodule // dmem_asserts
bind data_memory_addressing dmem_asserts #(.DEPTH(DEPTH)) u_chk (.clk_sys(clk_sys),
  .rstn(rstn), .req(req), .sfr_rdata(sfr_rdata), .rsp(rsp), .sfr_we(sfr_we),
  .sfr_re(sfr_re), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
  .active_bank(active_bank), .stack_ptr(stack_ptr));

// >>> verif/sfr_space_model.sv
// Purpose: External special function register space
// Assumes: Read data sampled around the read strobe
// Notes: Outside a read the data is inverted so stale values never match
`timescale 1ns/1ns
module sfr_space_model (
  input wire logic clk_sys,
  input wire logic sfr_we,
  input wire logic sfr_re,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata
);
  logic [7:0] regs_q [256];
  logic rd_q;
  always_ff @(posedge clk_sys) begin
    if (sfr_we) regs_q[sfr_addr] <= sfr_wdata;
    rd_q <= sfr_re;
  end
  assign sfr_rdata = (sfr_re || rd_q) ? regs_q[sfr_addr] : ~regs_q[sfr_addr];
endmodule // sfr_space_model

// >>> verif/data_memory_addressing_tb.sv
// Purpose: Self-checking bench for data_memory_addressing
// Assumes: One request at a time, held until rsp.valid
// Notes: Random values from a fixed seed
`timescale 1ns/1ns
module data_memory_addressing_tb import dmem_pkg::*;;
  logic clk_sys, rstn, sfr_we, sfr_re;
  mem_req_t req;
  mem_rsp_t rsp, r;
  logic [7:0] sfr_rdata, sfr_addr, sfr_wdata, stack_ptr, v, p;
  logic [1:0] active_bank;
  logic [3:0] a;
  logic [2:0] b;
  int mismatches = 0, n_tests = 0, cyc = 0;
  data_memory_addressing DUT (.clk_sys(clk_sys), .rstn(rstn), .req(req),
    .sfr_rdata(sfr_rdata), .rsp(rsp), .sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .active_bank(active_bank), .stack_ptr(stack_ptr));
  sfr_space_model u_sfr (.clk_sys(clk_sys), .sfr_we(sfr_we), .sfr_re(sfr_re),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  function automatic logic [7:0] bit_addr(logic [3:0] off, logic [2:0] pos);
    return 8'(off) * 8'h08 + 8'(pos);
  endfunction
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Request held until the answer edge, then a free edge before the next one
  task automatic op(op_kind_t k, logic w, logic [7:0] ad, logic [7:0] d);
    int n;
    n = 0;
    req <= '{1'b1, k, w, ad, d};
    @(posedge clk_sys);
    while (rsp.valid !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    r = rsp;
    req.valid <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    rstn = 1'b0;
    req = '0;
    void'($urandom(32'hd79e));
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    chk(stack_ptr, 8'h07);
    v = 8'($urandom);
    op(OP_PUSH, 1'b1, 8'h00, v);
    chk(stack_ptr, 8'h08);
    op(OP_DIRECT, 1'b1, STATUS_WORD_ADDR, 8'h08);
    chk(8'(active_bank), 8'h01);
    op(OP_REGNAME, 1'b0, 8'h00, 8'h00);
    chk(r.rdata, v);
    op(OP_POP, 1'b0, 8'h00, 8'h00);
    chk(r.rdata, v);
    chk(stack_ptr, 8'h07);
    $display("stack and bank test done");
    p = 8'h80 | 8'($urandom);
    op(OP_REGNAME, 1'b1, 8'h01, p);
    op(OP_INDIRECT, 1'b1, 8'h01, v);
    op(OP_INDIRECT, 1'b0, 8'h01, 8'h00);
    chk(r.rdata, v);
    chk(8'(r.to_sfr), 8'h00);
    // Only occupied special addresses are touched
    op(OP_DIRECT, 1'b1, 8'h90, v);
    op(OP_DIRECT, 1'b0, 8'h90, 8'h00);
    chk(r.rdata, v);
    chk(8'(r.sfr_bit_ok), 8'h01);
    op(OP_DIRECT, 1'b0, 8'h99, 8'h00);
    chk(8'(r.sfr_bit_ok), 8'h00);
    op(OP_BIT, 1'b1, 8'h95, {7'h00, ~v[5]});
    op(OP_BIT, 1'b0, 8'h95, 8'h00);
    chk(8'(r.bit_val), {7'h00, ~v[5]});
    chk(8'(r.sfr_bit_ok), 8'h01);
    op(OP_DIRECT, 1'b0, 8'h90, 8'h00);
    chk(r.rdata, v ^ 8'h20);
    op(OP_BIT, 1'b1, 8'hD4, 8'h01);
    chk(8'(active_bank), 8'h03);
    op(OP_REGNAME, 1'b1, 8'h02, v);
    op(OP_DIRECT, 1'b0, 8'h1A, 8'h00);
    chk(r.rdata, v);
    $display("indirect and special test done");
    for (int i = 0; i < 5; i++) begin
      a = (i == 0) ? 4'hF : 4'($urandom);
      b = (i == 0) ? 3'h7 : 3'($urandom);
      v = 8'($urandom);
      op(OP_DIRECT, 1'b1, BIT_AREA_BASE + 8'(a), v);
      op(OP_BIT, 1'b0, bit_addr(a, b), 8'h00);
      chk(8'(r.bit_val), 8'(v[b]));
    end
    op(OP_DIRECT, 1'b1, 8'h22, 8'h00);
    op(OP_BIT, 1'b1, 8'h13, 8'h01);
    op(OP_DIRECT, 1'b0, 8'h22, 8'h00);
    chk(r.rdata, 8'h08);
    $display("bit area test done");
    op(OP_DIRECT, 1'b1, STACK_PTR_ADDR, 8'hFF);
    chk(stack_ptr, 8'hFF);
    op(OP_PUSH, 1'b1, 8'h00, v);
    chk(stack_ptr, 8'h00);
    op(OP_DIRECT, 1'b0, STACK_PTR_ADDR, 8'h00);
    chk(r.rdata, 8'h00);
    $display("stack wrap test done");
    results();
  end
endmodule // data_memory_addressing_tb
